/* File: hw/gmc_params.svh */
// Constants for the general mask and configuration register block.
// Assumes an internal register port already decoded from the serial bus.
`ifndef GMC_PARAMS_SVH
`define GMC_PARAMS_SVH
// ****************************************
// Register map and fields
// ****************************************
`define GMC_CMD_GENERAL 8'h17
`define GMC_CMD_PRIO_1BIT 8'h15
`define GMC_CMD_PRIO_3BIT_A 8'h27
`define GMC_CMD_PRIO_3BIT_B 8'h28
`define GMC_RESET_VALUE 8'h80
`define GMC_BIT_IRQ_EN 7
`define GMC_BIT_WIDE 5
`define GMC_BIT_MPRIO 4
`define GMC_BIT_CLS_CHG 3
`define GMC_BIT_DET_CHG 2
// ****************************************
// Timing
// ****************************************
`define GMC_CLK_MHZ 125
`define GMC_PCUT_EXTRA_MS 6
`define GMC_PCUT_EXTRA_CYC (`GMC_PCUT_EXTRA_MS * 1000 * `GMC_CLK_MHZ)
`endif

/* File: hw/gmc_pkg.sv */
// Types shared by the general mask and configuration block.
// Assumes gmc_params.svh is on the include path.
package gmc_pkg;
    // Fault timer states for one channel
    typedef enum logic [1:0] {
        GMC_IDLE,
        GMC_TIMING,
        GMC_TRIPPED
    } gmc_fault_state_t;
endpackage

/* File: hw/gmc_channel.sv */
// One channel: event flag qualification and timeout fault handling.
// Assumes all inputs are synchronous to clk_in.
`timescale 1ns/100ps
`include "gmc_params.svh"
module gmc_channel
    import gmc_pkg::*;
#(
    parameter int CNT_W = 24,
    parameter int RES_W = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Configuration
    input wire logic class_change_only_in,
    input wire logic detect_change_only_in,
    input wire logic [CNT_W-1:0] ovld_limit_in,
    input wire logic [CNT_W-1:0] pcut_extra_in,
    // Discovery results
    input wire logic class_done_in,
    input wire logic [RES_W-1:0] class_result_in,
    input wire logic detect_done_in,
    input wire logic [RES_W-1:0] detect_result_in,
    // Faults
    input wire logic timeout_fault_in,
    input wire logic pcut_overload_in,
    input wire logic pcut_four_pair_in,
    // Outputs
    output logic class_event_out,
    output logic detect_event_out,
    output logic pcut_fault_out,
    output logic power_clear_out
);
    logic [RES_W-1:0] last_class;
    logic [RES_W-1:0] last_detect;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;
    gmc_fault_state_t state;

    // ****************************************
    // Event qualification
    // ****************************************
    // Remember previous results for change-only mode
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            last_class <= '0;
            last_detect <= '0;
            class_event_out <= 1'b0;
            detect_event_out <= 1'b0;
        end else begin
            class_event_out <= class_done_in &&
                (!class_change_only_in || class_result_in != last_class);
            detect_event_out <= detect_done_in &&
                (!detect_change_only_in || detect_result_in != last_detect);
            if (class_done_in) begin
                last_class <= class_result_in;
            end
            if (detect_done_in) begin
                last_detect <= detect_result_in;
            end
        end
    end

    // ****************************************
    // Fault timing
    // ****************************************
    // Four-pair cuts wait the overload time plus the extra margin
    assign limit = pcut_four_pair_in ? CNT_W'(ovld_limit_in + pcut_extra_in)
                                     : ovld_limit_in;

    // Counter never trips early, so the setting acts as a minimum
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= GMC_IDLE;
            count <= '0;
            pcut_fault_out <= 1'b0;
        end else begin
            pcut_fault_out <= 1'b0;
            case (state)
                GMC_IDLE: begin
                    count <= '0;
                    if (pcut_overload_in) begin
                        state <= GMC_TIMING;
                    end
                end
                GMC_TIMING: begin
                    if (!pcut_overload_in) begin
                        state <= GMC_IDLE;
                    end else if (count >= limit) begin
                        state <= GMC_TRIPPED;
                        pcut_fault_out <= 1'b1;
                    end else begin
                        count <= CNT_W'(count + 1'b1);
                    end
                end
                GMC_TRIPPED: begin
                    if (!pcut_overload_in) begin
                        state <= GMC_IDLE;
                    end
                end
                default: state <= GMC_IDLE;
            endcase
        end
    end

    // Any timeout fault drops power status
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            power_clear_out <= 1'b0;
        end else begin
            power_clear_out <= timeout_fault_in || pcut_fault_out;
        end
    end
endmodule // gmc_channel

/* File: hw/gmc_general_mask.sv */
// General mask and configuration register with per-channel event and fault logic.
// Assumes the serial bus front end hands over decoded command, data and strobes.
`timescale 1ns/100ps
`include "gmc_params.svh"
module gmc_general_mask
    import gmc_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int CNT_W = 24,
    parameter int RES_W = 4,
    parameter int PCUT_EXTRA_CYC = `GMC_PCUT_EXTRA_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Register port from the serial front end
    input wire logic [7:0] cmd_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // Interrupt path
    input wire logic irq_request_in,
    output logic irq_out,
    // Configuration outputs
    output logic wide_access_select_out,
    output logic multi_bit_priority_select_out,
    output logic [7:0] prio_cmd_lo_out,
    output logic [7:0] prio_cmd_hi_out,
    // Overload limit common to all channels; per-channel discovery and faults
    input wire logic [CNT_W-1:0] ovld_limit_in,
    input wire logic [CHANNELS-1:0] class_done_in,
    input wire logic [CHANNELS*RES_W-1:0] class_result_in,
    input wire logic [CHANNELS-1:0] detect_done_in,
    input wire logic [CHANNELS*RES_W-1:0] detect_result_in,
    input wire logic [CHANNELS-1:0] timeout_fault_in,
    input wire logic [CHANNELS-1:0] pcut_overload_in,
    input wire logic [CHANNELS-1:0] pcut_four_pair_in,
    // Per-channel outputs and power set inputs
    output logic [CHANNELS-1:0] class_event_flag_out,
    output logic [CHANNELS-1:0] detect_event_flag_out,
    output logic [CHANNELS-1:0] power_good_flag_out,
    output logic [CHANNELS-1:0] power_enable_flag_out,
    input wire logic [CHANNELS-1:0] power_good_set_in,
    input wire logic [CHANNELS-1:0] power_enable_set_in
);
    logic [7:0] general_interrupt_config;
    logic wr_hit;
    logic rd_hit;
    logic irq_pin_enable;
    logic wide_access_select;
    logic multi_bit_priority_select;
    logic class_change_only;
    logic detect_change_only;
    logic [CHANNELS-1:0] class_evt;
    logic [CHANNELS-1:0] detect_evt;
    logic [CHANNELS-1:0] power_clear;

    // Command match, shared by the write and read paths
    function automatic logic hit(input logic [7:0] cmd, input logic [7:0] code);
        hit = (cmd == code);
    endfunction

    // ****************************************
    // Register access
    // ****************************************
    // Strobes aimed at this register only
    assign wr_hit = write_in && hit(cmd_in, `GMC_CMD_GENERAL);
    assign rd_hit = read_in && hit(cmd_in, `GMC_CMD_GENERAL);

    // All bits writable; spare bits just store
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            general_interrupt_config <= `GMC_RESET_VALUE;
        end else if (wr_hit) begin
            general_interrupt_config <= wdata_in;
        end
    end

    // Valid pulse one cycle after the read strobe
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd_hit;
        end
    end

    // Data is zero outside the answer so a shared read bus can OR it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_hit ? general_interrupt_config : 8'h00;
        end
    end

    // ****************************************
    // Field view
    // ****************************************
    // Named fields keep the bit positions in one place
    assign irq_pin_enable = general_interrupt_config[`GMC_BIT_IRQ_EN];
    assign wide_access_select = general_interrupt_config[`GMC_BIT_WIDE];
    assign multi_bit_priority_select = general_interrupt_config[`GMC_BIT_MPRIO];
    assign class_change_only = general_interrupt_config[`GMC_BIT_CLS_CHG];
    assign detect_change_only = general_interrupt_config[`GMC_BIT_DET_CHG];

    // ****************************************
    // Configuration outputs
    // ****************************************
    // Gate only the pin; events keep latching upstream regardless
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_request_in && irq_pin_enable;
        end
    end

    // Address mode for the front end, which decodes A0 itself
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wide_access_select_out <= 1'b0;
        end else begin
            wide_access_select_out <= wide_access_select;
        end
    end

    // Priority width for the shutdown decoder
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            multi_bit_priority_select_out <= 1'b0;
        end else begin
            multi_bit_priority_select_out <= multi_bit_priority_select;
        end
    end

    // Priority table commands; the 1-bit table is a single register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prio_cmd_lo_out <= `GMC_CMD_PRIO_1BIT;
            prio_cmd_hi_out <= `GMC_CMD_PRIO_1BIT;
        end else if (multi_bit_priority_select) begin
            prio_cmd_lo_out <= `GMC_CMD_PRIO_3BIT_A;
            prio_cmd_hi_out <= `GMC_CMD_PRIO_3BIT_B;
        end else begin
            prio_cmd_lo_out <= `GMC_CMD_PRIO_1BIT;
            prio_cmd_hi_out <= `GMC_CMD_PRIO_1BIT;
        end
    end

    // ****************************************
    // Channels
    // ****************************************
    // One timer per channel; the four-pair margin is common to all
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_ch
            gmc_channel #(
                .CNT_W(CNT_W),
                .RES_W(RES_W)
            ) u_ch (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .class_change_only_in(class_change_only),
                .detect_change_only_in(detect_change_only),
                .ovld_limit_in(ovld_limit_in),
                .pcut_extra_in(CNT_W'(PCUT_EXTRA_CYC)),
                .class_done_in(class_done_in[g]),
                .class_result_in(class_result_in[g*RES_W +: RES_W]),
                .detect_done_in(detect_done_in[g]),
                .detect_result_in(detect_result_in[g*RES_W +: RES_W]),
                .timeout_fault_in(timeout_fault_in[g]),
                .pcut_overload_in(pcut_overload_in[g]),
                .pcut_four_pair_in(pcut_four_pair_in[g]),
                .class_event_out(class_evt[g]),
                .detect_event_out(detect_evt[g]),
                .pcut_fault_out(),
                .power_clear_out(power_clear[g])
            );
        end
    endgenerate

    // ****************************************
    // Per-channel status outputs
    // ****************************************
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_out
            // Event pulses re-timed so each output leaves a flip-flop
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    class_event_flag_out[g] <= 1'b0;
                    detect_event_flag_out[g] <= 1'b0;
                end else begin
                    class_event_flag_out[g] <= class_evt[g];
                    detect_event_flag_out[g] <= detect_evt[g];
                end
            end
            // Fault clear wins over a simultaneous set: power must drop
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    power_good_flag_out[g] <= 1'b0;
                end else if (power_clear[g]) begin
                    power_good_flag_out[g] <= 1'b0;
                end else if (power_good_set_in[g]) begin
                    power_good_flag_out[g] <= 1'b1;
                end
            end
            // Enable status follows the same priority
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    power_enable_flag_out[g] <= 1'b0;
                end else if (power_clear[g]) begin
                    power_enable_flag_out[g] <= 1'b0;
                end else if (power_enable_set_in[g]) begin
                    power_enable_flag_out[g] <= 1'b1;
                end
            end
        end
    endgenerate
endmodule // gmc_general_mask

/* File: testbench/gmc_general_mask_checker.sv */
// Checker: timing relations at the general mask block ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module gmc_general_mask_checker #(
    parameter int CHANNELS = 8
) (
    // Clock, reset and register port
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] cmd_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    // Interrupt and configuration
    input wire logic irq_request_in,
    input wire logic irq_out,
    input wire logic wide_access_select_out,
    input wire logic multi_bit_priority_select_out,
    input wire logic [7:0] prio_cmd_lo_out,
    input wire logic [7:0] prio_cmd_hi_out,
    // Channels
    input wire logic [CHANNELS-1:0] class_done_in,
    input wire logic [CHANNELS-1:0] class_event_flag_out,
    input wire logic [CHANNELS-1:0] timeout_fault_in,
    input wire logic [CHANNELS-1:0] power_good_flag_out,
    input wire logic [CHANNELS-1:0] power_enable_flag_out
);
    logic [7:0] shadow;
    logic rd_hit;
    // Read strobe aimed at this register
    assign rd_hit = read_in && cmd_in == 8'h17;
    // Shadow of the register, written on the same edge as the design's copy
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            shadow <= 8'h80;
        end else if (write_in && cmd_in == 8'h17) begin
            shadow <= wdata_in;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    read_answer_a: assert property (
        $past(rd_hit && !reset_in) |-> rvalid_out && rdata_out == $past(shadow))
        else $error("read answer wrong");
    stray_answer_a: assert property (
        !$past(rd_hit) |-> !rvalid_out && rdata_out == 8'h00)
        else $error("answer without read");
    irq_gate_a: assert property (
        !$past(reset_in) |-> irq_out == ($past(irq_request_in) && $past(shadow[7])))
        else $error("interrupt gate wrong");
    wide_select_a: assert property (
        !$past(reset_in) |-> wide_access_select_out == $past(shadow[5]))
        else $error("width select wrong");
    prio_select_a: assert property (
        !$past(reset_in) |-> multi_bit_priority_select_out == $past(shadow[4]))
        else $error("priority select wrong");
    prio_cmd_a: assert property (
        {prio_cmd_lo_out, prio_cmd_hi_out} == (multi_bit_priority_select_out ? 16'h2728 : 16'h1515))
        else $error("priority registers wrong");
    class_every_a: assert property (
        class_done_in != '0 && !shadow[3] |-> ##2 class_event_flag_out == $past(class_done_in, 2))
        else $error("class event missing");
    event_cause_a: assert property (
        (class_event_flag_out & ~$past(class_done_in, 2)) == '0)
        else $error("class event without cycle");
    power_clear_a: assert property (
        ((power_good_flag_out | power_enable_flag_out) & $past(timeout_fault_in)
        & $past(timeout_fault_in, 2)) == '0)
        else $error("power kept on fault");
endmodule // gmc_general_mask_checker

bind gmc_general_mask gmc_general_mask_checker #(.CHANNELS(CHANNELS)) i_checker (
    .clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_in), .wdata_in(wdata_in),
    .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .irq_request_in(irq_request_in), .irq_out(irq_out),
    .wide_access_select_out(wide_access_select_out),
    .multi_bit_priority_select_out(multi_bit_priority_select_out),
    .prio_cmd_lo_out(prio_cmd_lo_out), .prio_cmd_hi_out(prio_cmd_hi_out),
    .class_done_in(class_done_in), .class_event_flag_out(class_event_flag_out),
    .timeout_fault_in(timeout_fault_in), .power_good_flag_out(power_good_flag_out),
    .power_enable_flag_out(power_enable_flag_out));

/* File: testbench/gmc_host_model.sv */
// Host model: issues register commands to the general mask block.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps
module gmc_host_model (
    // Clock
    input wire logic clk_in,
    // Register port towards the block
    output logic [7:0] cmd_out,
    output logic [7:0] wdata_out,
    output logic write_out,
    output logic read_out
);
    // Quiet bus at time zero
    initial begin
        cmd_out = 8'h00;
        wdata_out = 8'h00;
        write_out = 1'b0;
        read_out = 1'b0;
    end
    // One strobe cycle; after the taking edge the bus is scrambled, not held
    task automatic access(input logic wr, input logic [7:0] cmd, input logic [7:0] data);
        @(posedge clk_in);
        #1;
        cmd_out = cmd;
        wdata_out = data;
        write_out = wr;
        read_out = !wr;
        @(posedge clk_in);
        #1;
        write_out = 1'b0;
        read_out = 1'b0;
        cmd_out = ~cmd;
        wdata_out = ~data;
    endtask
endmodule // gmc_host_model

/* File: testbench/testbench.sv */
// Bench: register, interrupt, discovery event and power fault checks.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/100ps
module testbench;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] cmd_in, wdata_in, rdata_out, prio_cmd_lo_out, prio_cmd_hi_out, v, evc, evd;
    logic write_in, read_in, rvalid_out, irq_request_in, irq_out, ok;
    logic wide_access_select_out, multi_bit_priority_select_out;
    logic [1:0] sel;
    logic [23:0] ovld_limit_in;
    logic [31:0] class_result_in, detect_result_in;
    logic [7:0] class_done_in, detect_done_in, timeout_fault_in, pcut_overload_in;
    logic [7:0] pcut_four_pair_in, power_good_set_in, power_enable_set_in;
    logic [7:0] class_event_flag_out, detect_event_flag_out;
    logic [7:0] power_good_flag_out, power_enable_flag_out;
    logic [7:0] pat [4] = '{8'hFF, 8'h43, 8'h3C, 8'h00};
    logic [7:0] pcut_exp [4] = '{8'hFF, 8'hFE, 8'hFE, 8'hFC};
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    // Overload extra shortened to ten cycles to keep the run short
    gmc_general_mask #(.PCUT_EXTRA_CYC(10)) i_dut (
        .clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_in), .wdata_in(wdata_in),
        .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .irq_request_in(irq_request_in), .irq_out(irq_out),
        .wide_access_select_out(wide_access_select_out),
        .multi_bit_priority_select_out(multi_bit_priority_select_out),
        .prio_cmd_lo_out(prio_cmd_lo_out), .prio_cmd_hi_out(prio_cmd_hi_out),
        .ovld_limit_in(ovld_limit_in), .class_done_in(class_done_in),
        .class_result_in(class_result_in), .detect_done_in(detect_done_in),
        .detect_result_in(detect_result_in), .timeout_fault_in(timeout_fault_in),
        .pcut_overload_in(pcut_overload_in), .pcut_four_pair_in(pcut_four_pair_in),
        .class_event_flag_out(class_event_flag_out),
        .detect_event_flag_out(detect_event_flag_out),
        .power_good_flag_out(power_good_flag_out),
        .power_enable_flag_out(power_enable_flag_out),
        .power_good_set_in(power_good_set_in), .power_enable_set_in(power_enable_set_in));
    gmc_host_model i_host (.clk_in(clk_in), .cmd_out(cmd_in), .wdata_out(wdata_in),
        .write_out(write_in), .read_out(read_in));
    assign sel = {wide_access_select_out, multi_bit_priority_select_out};
    // Clock of 8 ns
    always #4 clk_in = ~clk_in;
    // Hang guard: the run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("Mismatches %0d of %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Answer is taken while it stands, the cycle after the strobe
    task automatic rd(input logic [7:0] cmd);
        i_host.access(1'b0, cmd, 8'h00);
        v = rdata_out;
        ok = rvalid_out;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Mode write, one discovery cycle on all channels, flags gathered
    task automatic ev(input logic [7:0] mode, input logic [3:0] res, input logic [15:0] exp);
        i_host.access(1'b1, 8'h17, mode);
        {class_done_in, detect_done_in} = 16'hFFFF;
        {class_result_in, detect_result_in} = {16{res}};
        {evc, evd} = 16'h0000;
        tick(1);
        {class_done_in, detect_done_in} = 16'h0000;
        repeat (4) begin
            evc |= class_event_flag_out;
            evd |= detect_event_flag_out;
            tick(1);
        end
        chk("class events", exp[15:8], evc);
        chk("detect events", exp[7:0], evd);
    endtask
    task automatic pwr();
        // Two edges, so a clear pulse still in flight from a fault cannot eat the set
        {power_good_set_in, power_enable_set_in} = 16'hFFFF;
        tick(2);
        {power_good_set_in, power_enable_set_in} = 16'h0000;
        tick(2);
    endtask
    // Main sequence
    initial begin
        {irq_request_in, ovld_limit_in} = {1'b1, 24'h000005};
        {class_done_in, detect_done_in, timeout_fault_in} = 24'h000000;
        {class_result_in, detect_result_in} = 64'h0;
        {pcut_overload_in, pcut_four_pair_in} = 16'h0000;
        {power_good_set_in, power_enable_set_in} = 16'h0000;
        tick(3);
        reset_in = 1'b0;
        rd(8'h17);
        chk("reset value", 8'h80, v);
        chk("read valid", 8'h01, {7'h00, ok});
        chk("irq on", 8'h01, {7'h00, irq_out});
        // Shutdown input is not wired here, so it is idle when priority select rises
        for (int i = 0; i < 4; i++) begin
            i_host.access(1'b1, 8'h17, pat[i]);
            rd(8'h17);
            chk("readback", pat[i], v);
            chk("selects", {6'h00, pat[i][5:4]}, {6'h00, sel});
            chk("irq gated", {7'h00, pat[i][7]}, {7'h00, irq_out});
            chk("prio low", pat[i][4] ? 8'h27 : 8'h15, prio_cmd_lo_out);
            chk("prio high", pat[i][4] ? 8'h28 : 8'h15, prio_cmd_hi_out);
        end
        // Foreign command is ignored and unanswered
        i_host.access(1'b1, 8'h16, 8'hFF);
        rd(8'h16);
        chk("stray answer", 8'h00, {7'h00, ok});
        rd(8'h17);
        chk("untouched", 8'h00, v);
        // Interrupt pin now disabled; events must still be latched
        ev(8'h00, 4'h3, 16'hFFFF);
        ev(8'h00, 4'h3, 16'hFFFF);
        ev(8'h08, 4'h3, 16'h00FF);
        ev(8'h08, 4'h5, 16'hFFFF);
        ev(8'h04, 4'h5, 16'hFF00);
        pwr();
        timeout_fault_in = 8'h05;
        tick(3);
        timeout_fault_in = 8'h00;
        chk("good cleared", 8'hFA, power_good_flag_out);
        chk("enable cleared", 8'hFA, power_enable_flag_out);
        // Two-pair overload on channel 0, four-pair on channel 1
        pwr();
        {pcut_overload_in, pcut_four_pair_in} = 16'h0302;
        for (int k = 1; k <= 20; k++) begin
            tick(1);
            if (k % 5 == 0) begin
                chk("overload", pcut_exp[k / 5 - 1], power_good_flag_out);
            end
        end
        stop_test();
    end
endmodule // testbench
